// >>> rtl/pin_mux_pkg.sv
// shared-pin mux constants
package pin_mux_pkg;
	// -------------------------------------------------
	// pin group layout
	// -------------------------------------------------
	localparam int PORT_A_WIDTH = 4;
	localparam int PORT_B_WIDTH = 8;
	localparam int PORT_C_WIDTH = 1;
	localparam int NUM_PINS = 13;
	// pin positions in the flat pin vector
	localparam int PIN_A0 = 0;
	localparam int PIN_A1 = 1;
	localparam int PIN_A2 = 2;
	localparam int PIN_A3 = 3;
	localparam int PIN_B0 = 4;
	localparam int PIN_B3 = 7;
	localparam int PIN_B6 = 10;
	localparam int PIN_B7 = 11;
	localparam int PIN_C0 = 12;
	localparam int NUM_SCMP = 3;
	localparam int NUM_TCMP = 3;
	// simple action control: two bits per channel
	localparam int SACT_WIDTH = 6;
	localparam logic [1:0] ACT_FORCE_LOW = 2'h0;
	localparam logic [1:0] ACT_ACTIVE_LOW = 2'h1;
	localparam logic [1:0] ACT_ACTIVE_HIGH = 2'h2;
	localparam logic [1:0] ACT_FORCE_HIGH = 2'h3;
	// -------------------------------------------------
	// reset values
	// -------------------------------------------------
	localparam logic [12:0] RST_ALT_SEL = 13'h0000;
	localparam logic [12:0] RST_DIR_OUT = 13'h0000;
	localparam logic [12:0] RST_OUT_VAL = 13'h0000;
	localparam logic RST_TRIP = 1'h0;
	// protect state machine
	typedef enum logic [1:0] {
		PROT_RUN = 2'b01,
		PROT_TRIPPED = 2'b10
	} prot_state_t;
endpackage

// >>> rtl/pin_sync_if.sv
// carrier for raw pin levels and synchronised copies
interface pin_sync_if #(parameter int W = 13);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport sync_side (input raw, output synced);
	modport user_side (output raw, input synced);
endinterface

// >>> rtl/pin_sync.sv
// two-stage synchroniser for pin inputs
module pin_sync #(
	parameter int W = 13
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	pin_sync_if.sync_side s
);
	// -------------------------------------------------
	// stages
	// -------------------------------------------------
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_stage2;

	// next values: first stage only feeds second
	always_comb begin
		next_stage1 = s.raw;
		next_stage2 = stage1;
		if (!i_rst_n) begin
			next_stage1 = '0;
			next_stage2 = '0;
		end
	end

	// register stages
	always_ff @(posedge i_mclk) begin
		stage1 <= next_stage1;
		stage2 <= next_stage2;
	end

	assign s.synced = stage2;
endmodule // pin_sync

// >>> rtl/shared_pin_function_mux.sv
// shared pin function multiplexer for ports a, b and c0
module shared_pin_function_mux
	import pin_mux_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// port logic controls
	input wire logic [12:0] i_alt_sel_wr,
	input wire logic [12:0] i_dir_out_wr,
	input wire logic [12:0] i_out_val_wr,
	input wire logic i_ctrl_we,
	output logic [12:0] o_port_in,
	// simple compare and timer compare sources
	input wire logic [2:0] i_scmp_match,
	input wire logic [5:0] i_simple_action_control,
	input wire logic [2:0] i_tcmp_out,
	// protect input (pin, active low) and its mask
	input wire logic i_power_drive_protect_irq_n,
	input wire logic i_protect_enable,
	// peripheral-side outputs
	output logic [3:0] o_conv_analog_sel,
	output logic o_timer_count_down,
	output logic o_timer_external_clock,
	output logic o_conv_start_input,
	output logic o_protect_tripped,
	// package pins
	input wire logic [12:0] i_pin,
	output logic [12:0] o_pin,
	output logic [12:0] o_pin_oe
);
	// -------------------------------------------------
	// input synchronisation
	// -------------------------------------------------
	pin_sync_if #(.W(NUM_PINS + 1)) sync_bus ();
	logic [12:0] pin_sync_val;
	logic protect_n_sync;

	assign sync_bus.raw = {i_power_drive_protect_irq_n, i_pin};
	assign pin_sync_val = sync_bus.synced[12:0];
	assign protect_n_sync = sync_bus.synced[13];

	pin_sync #(.W(NUM_PINS + 1)) u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.s(sync_bus.sync_side)
	);

	// -------------------------------------------------
	// control registers
	// -------------------------------------------------
	logic [12:0] alt_sel;
	logic [12:0] dir_out;
	logic [12:0] out_val;
	logic [12:0] next_alt_sel;
	logic [12:0] next_dir_out;
	logic [12:0] next_out_val;

	// reset leaves every pin a plain digital input
	always_comb begin
		next_alt_sel = alt_sel;
		next_dir_out = dir_out;
		next_out_val = out_val;
		if (!i_rst_n) begin
			next_alt_sel = RST_ALT_SEL;
			next_dir_out = RST_DIR_OUT;
			next_out_val = RST_OUT_VAL;
		end else if (i_ctrl_we) begin
			next_alt_sel = i_alt_sel_wr;
			next_dir_out = i_dir_out_wr;
			next_out_val = i_out_val_wr;
		end
	end

	// register controls
	always_ff @(posedge i_mclk) begin
		alt_sel <= next_alt_sel;
		dir_out <= next_dir_out;
		out_val <= next_out_val;
	end

	// -------------------------------------------------
	// protect trip state
	// -------------------------------------------------
	prot_state_t prot_state;
	prot_state_t next_prot_state;

	// trip while unmasked input is low; clears when released
	always_comb begin
		next_prot_state = prot_state;
		case (prot_state)
			PROT_RUN: begin
				if (i_protect_enable && !protect_n_sync)
					next_prot_state = PROT_TRIPPED;
			end
			PROT_TRIPPED: begin
				if (!i_protect_enable || protect_n_sync)
					next_prot_state = PROT_RUN;
			end
			default: next_prot_state = PROT_RUN;
		endcase
		if (!i_rst_n)
			next_prot_state = PROT_RUN;
	end

	// register protect state
	always_ff @(posedge i_mclk) begin
		prot_state <= next_prot_state;
	end

	assign o_protect_tripped = (prot_state == PROT_TRIPPED);

	// -------------------------------------------------
	// simple compare level from action control
	// -------------------------------------------------
	function automatic logic action_level(input logic [1:0] act, input logic match);
		case (act)
			ACT_FORCE_LOW: action_level = 1'b0;
			ACT_ACTIVE_LOW: action_level = ~match;
			ACT_ACTIVE_HIGH: action_level = match;
			default: action_level = 1'b1;
		endcase
	endfunction

	// -------------------------------------------------
	// pin drive
	// -------------------------------------------------
	logic [12:0] next_pin;
	logic [12:0] next_pin_oe;
	logic [12:0] pin_r;
	logic [12:0] pin_oe_r;
	logic trip_now;

	assign trip_now = i_protect_enable && !protect_n_sync;

	// choose bit i/o or alternate drive per pin
	always_comb begin
		next_pin = out_val;
		next_pin_oe = dir_out & ~alt_sel;
		for (int k = 0; k < NUM_SCMP; k++) begin
			if (alt_sel[PIN_B0 + k]) begin
				next_pin[PIN_B0 + k] = action_level(
					i_simple_action_control[2*k +: 2], i_scmp_match[k]);
				next_pin_oe[PIN_B0 + k] = !trip_now;
			end
		end
		for (int k = 0; k < NUM_TCMP; k++) begin
			if (alt_sel[PIN_B3 + k]) begin
				next_pin[PIN_B3 + k] = i_tcmp_out[k];
				next_pin_oe[PIN_B3 + k] = !trip_now;
			end
		end
		// bit i/o outputs on compare pins also float on trip
		if (trip_now) begin
			next_pin_oe[PIN_B0 +: 6] = '0;
		end
		if (!i_rst_n) begin
			next_pin = RST_OUT_VAL;
			next_pin_oe = RST_DIR_OUT;
		end
	end

	// register pin drive
	always_ff @(posedge i_mclk) begin
		pin_r <= next_pin;
		pin_oe_r <= next_pin_oe;
	end

	assign o_pin = pin_r;
	assign o_pin_oe = pin_oe_r;

	// -------------------------------------------------
	// peripheral-side inputs
	// -------------------------------------------------
	logic [12:0] next_port_in;
	logic [3:0] next_conv_sel;
	logic next_count_down;
	logic next_ext_clk;
	logic next_conv_start;
	logic [12:0] port_in_r;
	logic [3:0] conv_sel_r;
	logic count_down_r;
	logic ext_clk_r;
	logic conv_start_r;

	// route alternate inputs, gated low when not selected
	always_comb begin
		next_port_in = pin_sync_val;
		next_conv_sel = alt_sel[PIN_A3:PIN_A0];
		next_count_down = alt_sel[PIN_B6] & pin_sync_val[PIN_B6];
		next_ext_clk = alt_sel[PIN_B7] & pin_sync_val[PIN_B7];
		next_conv_start = alt_sel[PIN_C0] & pin_sync_val[PIN_C0];
		if (!i_rst_n) begin
			next_port_in = '0;
			next_conv_sel = '0;
			next_count_down = 1'b0;
			next_ext_clk = 1'b0;
			next_conv_start = 1'b0;
		end
	end

	// register peripheral inputs
	always_ff @(posedge i_mclk) begin
		port_in_r <= next_port_in;
		conv_sel_r <= next_conv_sel;
		count_down_r <= next_count_down;
		ext_clk_r <= next_ext_clk;
		conv_start_r <= next_conv_start;
	end

	assign o_port_in = port_in_r;
	// bits 1:0 converter a inputs, bits 3:2 converter b inputs
	assign o_conv_analog_sel = conv_sel_r;
	assign o_timer_count_down = count_down_r;
	assign o_timer_external_clock = ext_clk_r;
	assign o_conv_start_input = conv_start_r;

	// -------------------------------------------------
	// checks
	// -------------------------------------------------
	a_reset_inputs: assert property (@(posedge i_mclk)
		!i_rst_n |=> (alt_sel == 13'h0000) && (o_pin_oe == 13'h0000)) else $error("reset left a pin driven");
	a_reset_nodrive: assert property (@(posedge i_mclk)
		$rose(i_rst_n) |-> (o_pin_oe == 13'h0000) && !o_conv_start_input) else $error("pin not input at reset");
	a_scmp_float: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		trip_now |=> (o_pin_oe[PIN_B0 +: 3] == 3'h0)) else $error("simple compare pin driven on trip");
	a_tcmp_float: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		trip_now |=> (o_pin_oe[PIN_B3 +: 3] == 3'h0)) else $error("timer compare pin driven on trip");
	a_scmp_level: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		alt_sel[PIN_B0] && i_simple_action_control[1:0] == ACT_ACTIVE_HIGH
		|=> o_pin[PIN_B0] == $past(i_scmp_match[0])) else $error("simple compare level wrong");
	a_dir_route: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		alt_sel[PIN_B6] |=> o_timer_count_down == $past(pin_sync_val[PIN_B6])) else $error("direction not routed");
	a_clk_route: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		alt_sel[PIN_B7] |=> o_timer_external_clock == $past(pin_sync_val[PIN_B7])) else $error("timer clock not routed");
	a_soc_route: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_pin[PIN_C0] && alt_sel[PIN_C0] ##1 alt_sel[PIN_C0][*3] |-> o_conv_start_input) else $error("start not routed");
	a_sel_dir: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!alt_sel[PIN_A0] && dir_out[PIN_A0] |=> o_pin_oe[PIN_A0]) else $error("bit output not driven");
	a_conv_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		alt_sel[PIN_A2] |=> o_conv_analog_sel[2] && !o_pin_oe[PIN_A2]) else $error("converter b select wrong");
endmodule // shared_pin_function_mux

// >>> bench/pin_partner.sv
// far-side model: resolves each package pin level
module pin_partner (
	input wire logic i_mclk,
	input wire logic [12:0] i_oe,
	input wire logic [12:0] i_drv,
	input wire logic [12:0] i_ext_en,
	input wire logic [12:0] i_ext_val,
	output logic [12:0] o_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] flt = 13'h0000;
	// released pins wander so a stale level never reads as valid
	always @(posedge i_mclk) begin
		flt <= ~flt;
	end
	// device drive wins, else the outside party, else floating
	assign o_level = (i_oe & i_drv) | (~i_oe & ((i_ext_en & i_ext_val) | (~i_ext_en & flt)));
endmodule // pin_partner

// >>> bench/testbench.sv
// self-checking bench for the shared pin mux
module testbench
	import pin_mux_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {int kind; logic [12:0] mask; logic [12:0] exp;} note_t;
	note_t notes[$];
	logic i_mclk = 0, i_rst_n = 0, we = 0, prot_n = 1, prot_en = 0;
	logic [12:0] alt = 0, dir = 0, val = 0, ext_en = 0, ext_val = 0, e, d;
	logic [5:0] sact = 0;
	logic [2:0] scmp = 0, tcmp = 0;
	logic [12:0] port_in, pin, oe, level;
	logic [3:0] conv_sel;
	logic cdown, eclk, cstart, tripped;
	logic [31:0] rnd = 32'h958F;
	int error_cnt = 0, compares = 0, cyc = 0, i;
	always #12.5 i_mclk = ~i_mclk;
	shared_pin_function_mux i_shared_pin_function_mux (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_alt_sel_wr(alt), .i_dir_out_wr(dir), .i_out_val_wr(val), .i_ctrl_we(we),
		.o_port_in(port_in), .i_scmp_match(scmp), .i_simple_action_control(sact),
		.i_tcmp_out(tcmp), .i_power_drive_protect_irq_n(prot_n), .i_protect_enable(prot_en),
		.o_conv_analog_sel(conv_sel), .o_timer_count_down(cdown), .o_timer_external_clock(eclk),
		.o_conv_start_input(cstart), .o_protect_tripped(tripped), .i_pin(level), .o_pin(pin),
		.o_pin_oe(oe));
	pin_partner i_pin_partner (.i_mclk(i_mclk), .i_oe(oe), .i_drv(pin), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_level(level));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected level of one simple compare channel
	function automatic logic lv(input logic [1:0] c, input logic m);
		return (c == ACT_FORCE_HIGH) | ((c == ACT_ACTIVE_HIGH) & m) | ((c == ACT_ACTIVE_LOW) & ~m);
	endfunction
	task automatic wt(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task automatic put(input int k, input logic [12:0] m, input logic [12:0] x);
		note_t n;
		n.kind = k;
		n.mask = m;
		n.exp = x;
		notes.push_back(n);
	endtask
	// one control write, then let it reach the pins
	task automatic wr(input logic [12:0] a, input logic [12:0] dd, input logic [12:0] v);
		alt = a;
		dir = dd;
		val = v;
		we = 1;
		wt(1);
		we = 0;
		wt(4);
	endtask
	task automatic cmp(input logic [12:0] got, input logic [12:0] m, input logic [12:0] x);
		compares++;
		if ((got & m) !== (x & m)) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got & m, x & m);
		end
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// monitor: settled outputs against every pending note
	always @(negedge i_mclk) begin
		note_t n;
		#5;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.kind)
				0: cmp(oe, n.mask, n.exp);
				1: cmp(pin, n.mask, n.exp);
				2: cmp(port_in, n.mask, n.exp);
				default: cmp({5'h00, conv_sel, cdown, eclk, cstart, tripped}, n.mask, n.exp);
			endcase
		end
	end
	// hang guard
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		wt(2);
		i_rst_n = 1;
		put(0, 13'h1FFF, 13'h0000);
		put(3, 13'h1FFF, 13'h0000);
		wt(1);
		// bit i/o both ways with random direction and data
		for (i = 0; i < 8; i++) begin
			rnd = nxt(rnd);
			d = rnd[12:0];
			ext_en = ~rnd[12:0];
			ext_val = rnd[31:19];
			rnd = nxt(rnd);
			wr(13'h0000, d, rnd[12:0]);
			put(0, 13'h1FFF, d);
			put(1, d, rnd[12:0]);
			put(2, ~d, ext_val);
			wt(1);
		end
		// analog role, one pin at a time
		for (i = 0; i < 4; i++) begin
			wr(13'(1 << i), 13'h000F, 13'h000F);
			put(0, 13'h000F, 13'h000F & ~13'(1 << i));
			put(3, 13'h00F0, 13'(16 << i));
			wt(1);
		end
		// direction, external clock and start pins
		wr(13'h1C00, 13'h0000, 13'h0000);
		ext_en = 13'h1C00;
		for (i = 0; i < 6; i++) begin
			rnd = nxt(rnd);
			ext_val = rnd[12:0];
			wt(4);
			put(3, 13'h000E, {9'h000, ext_val[10], ext_val[11], ext_val[12], 1'b0});
		end
		// compare outputs, every action code on channel 0
		wr(13'h03F0, 13'h0000, 13'h0000);
		for (i = 0; i < 8; i++) begin
			rnd = nxt(rnd);
			sact = {rnd[3:0], 2'(i)};
			scmp = {rnd[5:4], 1'(i >> 2)};
			tcmp = rnd[8:6];
			wt(2);
			e = {3'h0, tcmp, lv(sact[5:4], scmp[2]), lv(sact[3:2], scmp[1]), lv(sact[1:0], scmp[0]), 4'h0};
			put(0, 13'h03F0, 13'h03F0);
			put(1, 13'h0070, e);
			put(1, 13'h0380, e);
		end
		// unmasked protect trip floats b0-b5, then masked
		prot_en = 1;
		prot_n = 0;
		wt(4);
		put(0, 13'h03F0, 13'h0000);
		put(3, 13'h0001, 13'h0001);
		prot_en = 0;
		wt(4);
		put(0, 13'h03F0, 13'h03F0);
		put(3, 13'h0001, 13'h0000);
		prot_n = 1;
		// reset in mid-run returns every pin to input
		wt(1);
		i_rst_n = 0;
		wt(1);
		put(0, 13'h1FFF, 13'h0000);
		put(3, 13'h1FFF, 13'h0000);
		put(2, 13'h1FFF, 13'h0000);
		wt(1);
		i_rst_n = 1;
		wt(2);
		test_done();
	end
endmodule // testbench
